/* logic/scw_pkg.sv */
// Constants and types for the scan-cycle watchdog and task scheduler
// Summary of operation
// - Main scan runs internal processing, input read, program, output write in order.
// - Periodic mode idles in internal processing until the main period ends.
// - Scan longer than period sets period overrun flag, finishes, writes outputs, restarts.
// - In stop: internal processing, input read, outputs fall back or hold.
// - Main scan time checked against scan limit, default 250 ms, maximum 500 ms.
// - Watchdog expiry marks application faulty, halts at once, alarm output goes 0.
// - Watchdog overrun flag set when any scan exceeds the watchdog limit; only main and periodic scans are timed, event tasks are not.
// - Main period word in ms, loaded at cold restart, software may overwrite.
// - Main period 1 to 255 ms; countdown loaded at scan start, expiry starts scan.
// - Last, longest and shortest scan times kept for main and periodic tasks.
// - Scheduler holds main task, optional periodic task, optional event tasks.
// - Main active by default, periodic when programmed, event task on its event.
// - Event or periodic start suspends main task, runs to end, then resumes it; events wait for periodic.
// - Separate enable bits for main, periodic and event task groups.
// - Periodic task period configurable 1 to 255 ms, may exceed main period.
// - Periodic task watchdog overrun sets flag, marks faulty and halts.
// - Periodic period word loaded at cold restart, program may overwrite.
// - Cold restart clears periodic enable at end of first main scan.
// - Discrete channels assigned to main or periodic task in groups of 8.
// - Inputs of the event channel refreshed before its event task starts.
// - Number of events is 8, 16, 32 or 64, numbered from zero.
// - Inputs 0 to 3 of first slot trigger events 0 to 3 on chosen edge.
package scw_pkg;
  localparam int          CLK_HZ          = 40_000_000;
  localparam int          MS_CYCLES       = CLK_HZ / 1000;
  localparam logic [9:0]  LIMIT_DEF_MS    = 10'd250;
  localparam logic [9:0]  LIMIT_MAX_MS    = 10'd500;
  localparam logic [7:0]  MAIN_PER_DEF_MS = 8'd10;
  localparam logic [7:0]  FAST_PER_DEF_MS = 8'd5;
  localparam logic [15:0] SHORT_INIT      = 16'hffff;
  // Register offsets
  localparam logic [3:0] A_CTRL      = 4'h0;
  localparam logic [3:0] A_STATUS    = 4'h1;
  localparam logic [3:0] A_MPER      = 4'h2;
  localparam logic [3:0] A_PPER      = 4'h3;
  localparam logic [3:0] A_LIMIT     = 4'h4;
  localparam logic [3:0] A_M_LAST    = 4'h5;
  localparam logic [3:0] A_M_LONG    = 4'h6;
  localparam logic [3:0] A_M_SHORT   = 4'h7;
  localparam logic [3:0] A_P_LAST    = 4'h8;
  localparam logic [3:0] A_P_LONG    = 4'h9;
  localparam logic [3:0] A_P_SHORT   = 4'ha;
  localparam logic [3:0] A_GROUP     = 4'hb;
  localparam logic [3:0] A_EDGE      = 4'hc;
  // Control bits
  localparam int C_MAIN_EN = 0;
  localparam int C_PER_EN  = 1;
  localparam int C_EVT_EN  = 2;
  localparam int C_RUN     = 3;
  localparam int C_PERIODIC= 4;
  localparam int C_HOLD    = 5;
  localparam int C_FAST_PRG= 6;
  typedef enum {ST_IP, ST_IN, ST_PRG, ST_OUT, ST_WAIT, ST_HALT} scw_phase_t;
  typedef enum {T_NONE, T_MAIN, T_FAST, T_EVT} scw_task_t;
endpackage

/* logic/scw_scheduler.sv */
// Scan-cycle supervisor, watchdog and task scheduler
`timescale 1ns/100ps
module scw_scheduler
  import scw_pkg::*;
#(
  parameter int N_EVT  = 8,             // Events per variant: 8, 16, 32 or 64
  parameter int N_GRP  = 4,             // Discrete groups of 8 channels
  parameter int MS_CYC = MS_CYCLES      // Clock cycles per ms tick
)(
  input  wire logic             sys_clk,       // System clock, 40 MHz
  input  wire logic             rst_b,         // Async reset, cold restart
  input  wire logic [3:0]       reg_addr,      // Register address
  input  wire logic [15:0]      reg_wdata,     // Write data
  input  wire logic             reg_wr,        // Write strobe
  input  wire logic             reg_rd,        // Read strobe
  output logic      [15:0]      reg_rdata,     // Read data, cycle after strobe
  input  wire logic [N_EVT-1:0] evt_req,       // Event requests from I/O channels
  input  wire logic [3:0]       slot_in,       // First slot inputs 0 to 3
  input  wire logic             prog_done,     // Application finished its program
  output logic                  prog_start,    // Pulse: start program of a task
  output logic      [1:0]       prog_task,     // Task in program: 1 main 2 fast 3 event
  output logic      [5:0]       prog_evt,      // Event number being served
  output logic                  in_read,       // Pulse: read inputs
  output logic                  out_write,     // Pulse: write outputs
  output logic      [N_GRP-1:0] io_grp_sel,    // Groups taking part in the exchange
  output logic                  out_fallback,  // Outputs at fallback values
  output logic                  alarm_output,  // Alarm, low when faulty
  output logic                  app_fault      // Application faulty, halted
);
  logic [15:0] ctrl_q;
  logic [7:0] mper_q, pper_q;
  logic [9:0] limit_q;
  logic [N_GRP-1:0] grp_q;
  logic [3:0] edge_q, slot_q;
  logic per_ovf_q, wd_ovf_q, first_q;
  logic [15:0] m_last_q, m_long_q, m_short_q, p_last_q, p_long_q, p_short_q;
  logic [31:0] pre_q;
  logic tick;
  logic [7:0] mcnt_q, pcnt_q;
  logic [15:0] mtime_q, ptime_q;
  scw_phase_t mph_q, fph_q;
  scw_task_t act_q;
  logic fast_pend_q, fast_busy_q;
  logic [N_EVT-1:0] evt_pend_q;
  logic evt_busy_q;
  logic [5:0] evt_num_q;
  logic [1:0] eph_q;
  logic halt;
  logic main_end, fast_end, fast_due;
  logic mdone_q;

  // Lowest pending event number wins
  function automatic logic [5:0] first_set(input logic [N_EVT-1:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = N_EVT - 1; i >= 0; i--)
      if (v[i]) r = 6'(i);
    return r;
  endfunction

  // Running min/max of a scan time
  function automatic logic [15:0] pick(input logic [15:0] a, input logic [15:0] b, input logic hi);
    pick = hi ? ((a > b) ? a : b) : ((a < b) ? a : b);
  endfunction

  assign halt     = app_fault;
  assign main_end = (act_q == T_MAIN) && (mph_q == ST_OUT);
  assign fast_end = (act_q == T_FAST) && (fph_q == ST_OUT);
  assign fast_due = ctrl_q[C_FAST_PRG] && ctrl_q[C_PER_EN] && ctrl_q[C_RUN] && (pcnt_q <= 8'd1) && tick;

  // Millisecond time base
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) pre_q <= 32'h0;
    else if (pre_q == 32'(MS_CYC - 1)) pre_q <= 32'h0;
    else pre_q <= pre_q + 32'h1;
  assign tick = (pre_q == 32'(MS_CYC - 1));

  // Control register; hardware clears periodic enable after first main scan
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) ctrl_q <= 16'h0009;
    else if (first_q && main_end) ctrl_q[C_PER_EN] <= 1'b0;
    else if (reg_wr && reg_addr == A_CTRL) ctrl_q <= reg_wdata;

  // Period, limit, group and edge words
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      mper_q  <= MAIN_PER_DEF_MS;
      pper_q  <= FAST_PER_DEF_MS;
      limit_q <= LIMIT_DEF_MS;
      grp_q   <= '0;
      edge_q  <= 4'h0;
    end
    else if (reg_wr)
    begin
      // Zero period is refused so the countdown always expires
      if (reg_addr == A_MPER && reg_wdata[7:0] != 8'h0) mper_q <= reg_wdata[7:0];
      if (reg_addr == A_PPER && reg_wdata[7:0] != 8'h0) pper_q <= reg_wdata[7:0];
      if (reg_addr == A_LIMIT)
        limit_q <= (reg_wdata[9:0] > LIMIT_MAX_MS) ? LIMIT_MAX_MS : reg_wdata[9:0];
      if (reg_addr == A_GROUP) grp_q <= reg_wdata[N_GRP-1:0];
      if (reg_addr == A_EDGE) edge_q <= reg_wdata[3:0];
    end

  // First-scan marker after cold restart
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) first_q <= 1'b1;
    else if (main_end) first_q <= 1'b0;

  // Main countdown and scan time; counted on every tick, also while another task runs; scan time paused in wait
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      mcnt_q  <= 8'h0;
      mtime_q <= 16'h0;
    end
    else if (mph_q == ST_IP && act_q == T_MAIN && !halt)
    begin
      mcnt_q  <= mper_q;
      mtime_q <= 16'h0;
    end
    else if (tick)
    begin
      if (mcnt_q != 8'h0) mcnt_q <= mcnt_q - 8'h1;
      if (mph_q != ST_WAIT && mtime_q != 16'hffff) mtime_q <= mtime_q + 16'h1;
    end

  // Fast countdown and scan time
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      pcnt_q  <= 8'h0;
      ptime_q <= 16'h0;
    end
    else if (fast_due)
    begin
      pcnt_q  <= pper_q;
      ptime_q <= 16'h0;
    end
    else if (tick)
    begin
      if (pcnt_q > 8'd1) pcnt_q <= pcnt_q - 8'h1;
      if (fast_busy_q) ptime_q <= ptime_q + 16'h1;
    end

  // Pending requests: fast cycle start and events
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      fast_pend_q <= 1'b0;
      evt_pend_q  <= '0;
      slot_q      <= 4'h0;
    end
    else
    begin
      slot_q <= slot_in;
      if (fast_due) fast_pend_q <= 1'b1;
      else if (act_q == T_FAST && fph_q == ST_IP) fast_pend_q <= 1'b0;
      for (int i = 0; i < N_EVT; i++)
        // Set wins over the launch clear; inhibited events are lost
        if (ctrl_q[C_EVT_EN] && ctrl_q[C_RUN] &&
            (evt_req[i] || (i < 4 && ((slot_in[i & 3] ^ slot_q[i & 3]) &&
             (slot_in[i & 3] == !edge_q[i & 3])))))
          evt_pend_q[i] <= 1'b1;
        else if (act_q == T_EVT && eph_q == 2'd0 && evt_num_q == 6'(i))
          evt_pend_q[i] <= 1'b0;
    end

  // Task arbiter: event over fast over main; a started task runs to its end
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      act_q       <= T_MAIN;
      fast_busy_q <= 1'b0;
      evt_busy_q  <= 1'b0;
      evt_num_q   <= 6'h0;
    end
    else if (halt)
      act_q <= T_NONE;
    else if (!evt_busy_q && |evt_pend_q && !first_q && act_q != T_FAST)
    begin
      act_q      <= T_EVT;
      evt_busy_q <= 1'b1;
      evt_num_q  <= first_set(evt_pend_q);
    end
    else if (act_q == T_EVT && eph_q == 2'd3)
    begin
      evt_busy_q <= 1'b0;
      act_q      <= fast_busy_q ? T_FAST : T_MAIN;
    end
    else if (act_q == T_MAIN && fast_pend_q && !fast_busy_q && !first_q)
    begin
      act_q       <= T_FAST;
      fast_busy_q <= 1'b1;
    end
    else if (fast_end)
    begin
      fast_busy_q <= 1'b0;
      act_q       <= T_MAIN;
    end

  // Main program end that lands while a higher task takes over is kept, else main hangs
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) mdone_q <= 1'b0;
    else if (prog_done && mph_q == ST_PRG && act_q != T_MAIN &&
             !(act_q == T_FAST && fph_q == ST_PRG) && !(act_q == T_EVT && eph_q == 2'd2))
      mdone_q <= 1'b1;
    else if (act_q == T_MAIN) mdone_q <= 1'b0;

  // Main task phase sequence
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) mph_q <= ST_IP;
    else if (halt) mph_q <= ST_HALT;
    else if (act_q == T_MAIN)
      case (mph_q)
        ST_IP:   mph_q <= ST_IN;
        ST_IN:   mph_q <= (ctrl_q[C_RUN] && ctrl_q[C_MAIN_EN]) ? ST_PRG : ST_OUT;
        ST_PRG:  if (prog_done || mdone_q) mph_q <= ST_OUT;
        ST_OUT:  mph_q <= (ctrl_q[C_PERIODIC] && mcnt_q != 8'h0) ? ST_WAIT : ST_IP;
        ST_WAIT: if (mcnt_q == 8'h0) mph_q <= ST_IP;
        default: mph_q <= ST_HALT;
      endcase

  // Fast task phase sequence
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) fph_q <= ST_IP;
    else if (act_q == T_FAST)
      case (fph_q)
        ST_IP:   fph_q <= ST_IN;
        ST_IN:   fph_q <= ST_PRG;
        ST_PRG:  if (prog_done) fph_q <= ST_OUT;
        ST_OUT:  fph_q <= ST_IP;
        default: fph_q <= ST_IP;
      endcase

  // Event sequence: refresh channel inputs, program, write outputs
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) eph_q <= 2'd0;
    else if (act_q == T_EVT)
      case (eph_q)
        2'd0:    eph_q <= 2'd1;
        2'd1:    eph_q <= 2'd2;
        2'd2:    if (prog_done) eph_q <= 2'd3;
        default: eph_q <= 2'd0;
      endcase

  // Overrun flags and fault; flags are sticky until software writes status
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      per_ovf_q <= 1'b0;
      wd_ovf_q  <= 1'b0;
      app_fault <= 1'b0;
    end
    else
    begin
      if ((ctrl_q[C_PERIODIC] && mcnt_q == 8'h0 && mph_q inside {ST_IN, ST_PRG}) ||
          (fast_busy_q && fast_due))
        per_ovf_q <= 1'b1;
      else if (reg_wr && reg_addr == A_STATUS && reg_wdata[0]) per_ovf_q <= 1'b0;
      if ((mtime_q > 16'(limit_q) && mph_q != ST_WAIT && mph_q != ST_HALT) ||
          ptime_q > 16'(limit_q))
      begin
        wd_ovf_q  <= 1'b1;
        app_fault <= 1'b1;
      end
      else if (reg_wr && reg_addr == A_STATUS && reg_wdata[1]) wd_ovf_q <= 1'b0;
    end

  // Scan time records
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      m_last_q <= 16'h0; m_long_q <= 16'h0; m_short_q <= SHORT_INIT;
      p_last_q <= 16'h0; p_long_q <= 16'h0; p_short_q <= SHORT_INIT;
    end
    else
    begin
      if (main_end)
      begin
        m_last_q  <= mtime_q;
        m_long_q  <= pick(m_long_q, mtime_q, 1'b1);
        m_short_q <= pick(m_short_q, mtime_q, 1'b0);
      end
      if (fast_end)
      begin
        p_last_q  <= ptime_q;
        p_long_q  <= pick(p_long_q, ptime_q, 1'b1);
        p_short_q <= pick(p_short_q, ptime_q, 1'b0);
      end
    end

  // Strobes to I/O and program; group select follows the task owning the exchange
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      prog_start <= 1'b0; prog_task <= 2'd0; prog_evt <= 6'h0;
      in_read <= 1'b0; out_write <= 1'b0; io_grp_sel <= '0;
      out_fallback <= 1'b0; alarm_output <= 1'b1;
    end
    else
    begin
      in_read    <= (act_q == T_MAIN && mph_q == ST_IN) || (act_q == T_FAST && fph_q == ST_IN) ||
                    (act_q == T_EVT && eph_q == 2'd0);
      out_write  <= (main_end && ctrl_q[C_RUN]) || fast_end || (act_q == T_EVT && eph_q == 2'd3);
      prog_start <= (act_q == T_MAIN && mph_q == ST_IN && ctrl_q[C_RUN] && ctrl_q[C_MAIN_EN]) ||
                    (act_q == T_FAST && fph_q == ST_IN) || (act_q == T_EVT && eph_q == 2'd1);
      prog_task  <= 2'(act_q);
      prog_evt   <= evt_num_q;
      io_grp_sel <= (act_q == T_FAST) ? grp_q : ~grp_q;
      out_fallback <= !ctrl_q[C_RUN] && !ctrl_q[C_HOLD];
      alarm_output <= !halt;
    end

  // Register read port
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) reg_rdata <= 16'h0;
    else if (reg_rd)
      case (reg_addr)
        A_CTRL:    reg_rdata <= ctrl_q;
        A_STATUS:  reg_rdata <= {13'h0, app_fault, wd_ovf_q, per_ovf_q};
        A_MPER:    reg_rdata <= {8'h0, mper_q};
        A_PPER:    reg_rdata <= {8'h0, pper_q};
        A_LIMIT:   reg_rdata <= {6'h0, limit_q};
        A_M_LAST:  reg_rdata <= m_last_q;
        A_M_LONG:  reg_rdata <= m_long_q;
        A_M_SHORT: reg_rdata <= m_short_q;
        A_P_LAST:  reg_rdata <= p_last_q;
        A_P_LONG:  reg_rdata <= p_long_q;
        A_P_SHORT: reg_rdata <= p_short_q;
        A_GROUP:   reg_rdata <= 16'(grp_q);
        A_EDGE:    reg_rdata <= {12'h0, edge_q};
        default:   reg_rdata <= 16'h0;
      endcase
    else reg_rdata <= 16'h0;

  // Checks
  fault_alarm_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(app_fault) |=> !alarm_output) else $error("alarm not dropped on fault");
  fault_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    app_fault |=> app_fault) else $error("fault cleared");
  wd_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(app_fault) |-> $rose(wd_ovf_q)) else $error("fault without flag");
  limit_max_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    limit_q <= LIMIT_MAX_MS) else $error("limit above maximum");
  phase_order_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mph_q == ST_IN && act_q == T_MAIN && !halt) |=> mph_q inside {ST_PRG, ST_OUT})
    else $error("bad phase order");
  wait_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mph_q == ST_WAIT && mcnt_q != 8'h0 && !halt) |=> mph_q == ST_WAIT)
    else $error("left wait early");
  fallback_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!ctrl_q[C_RUN] && !ctrl_q[C_HOLD]) |=> out_fallback) else $error("no fallback");
  en_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (first_q && main_end) |=> !ctrl_q[C_PER_EN]) else $error("enable not cleared");
  short_max_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    main_end |=> m_last_q == $past(mtime_q) && m_short_q <= m_last_q && m_last_q <= m_long_q)
    else $error("scan time record wrong");
  evt_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (act_q == T_EVT && eph_q == 2'd0 && !halt) |=> in_read) else $error("no refresh");
  scan_c: cover property (@(posedge sys_clk) main_end ##1 mph_q == ST_WAIT);
  fast_c: cover property (@(posedge sys_clk) fast_end);
  evt_c:  cover property (@(posedge sys_clk) act_q == T_EVT && eph_q == 2'd3);
endmodule

/* dv/scw_app_model.sv */
// Application program and scan-order observer at the far side
`timescale 1ns/100ps
module scw_app_model (
  input  wire logic        sys_clk,    // System clock
  input  wire logic        rst_b,      // Async reset
  input  wire logic        prog_start, // Program start pulse
  input  wire logic        in_read,    // Input read pulse
  input  wire logic        out_write,  // Output write pulse
  input  wire logic [1:0]  prog_task,  // Task now served, one cycle behind
  input  wire logic [15:0] prg_len,    // Program run time in cycles
  output logic             prog_done,  // Program finished pulse
  output int               order_err,  // Scan order faults seen
  output int               n_start     // Programs started
);
  int         stk[$]; // Cycles left, innermost task last
  logic [1:0] tsk[$]; // Task owning each entry
  logic [1:0] ph;     // 0 idle, 1 inputs read, 2 program running
  // A preempted program resumes after the inner one, hence a stack;
  // a suspended program stands still while another task is served
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stk.delete();
      tsk.delete();
      prog_done <= 1'b0;
      order_err <= 0;
      n_start   <= 0;
      ph        <= 2'd0;
    end
    else
    begin
      prog_done <= 1'b0;
      if (stk.size() > 0 && tsk[$] == prog_task)
      begin
        if (stk[$] <= 1)
        begin
          void'(stk.pop_back());
          void'(tsk.pop_back());
          prog_done <= 1'b1;
        end
        else
          stk[$] = stk[$] - 1;
      end
      if (prog_start)
      begin
        stk.push_back(int'(prg_len));
        tsk.push_back(prog_task);
      end
      n_start   <= n_start + int'(prog_start);
      // Scan order seen at the pins: read, program, write; a read in the start cycle comes first
      order_err <= order_err + int'((prog_start && !in_read && ph != 2'd1) || (out_write && ph != 2'd2));
      ph        <= prog_start ? 2'd2 : in_read ? 2'd1 : out_write ? 2'd0 : ph;
    end
  end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the scan-cycle scheduler
`timescale 1ns/100ps
module tb_top;
  import scw_pkg::*;
  localparam int MSC = 8; // Short ms tick keeps the run brief
  logic        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0, slot_in = 4'h0, io_grp_sel;
  logic [15:0] reg_wdata = 16'h0000, prg_len = 16'h0014, reg_rdata, rd;
  logic [7:0]  evt_req = 8'h00;
  logic        prog_done, prog_start, in_read, out_write, out_fallback, alarm_output, app_fault;
  logic [1:0]  prog_task;
  logic [5:0]  prog_evt;
  logic [6:0]  sig;
  int          order_err, n_start, n0, t_in, cyc = 0, fail_count = 0, cmp_count = 0;
  // Clock, free cycle count and time of the last input read
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  always @(posedge sys_clk) if (in_read) t_in <= cyc;
  // Events to wait for: read, start, write, fault, fast, event, main
  assign sig = {prog_start && prog_task == 2'd1, prog_start && prog_task == 2'd3,
                prog_start && prog_task == 2'd2, app_fault, out_write, prog_start, in_read};
  scw_scheduler #(.N_EVT(8), .N_GRP(4), .MS_CYC(MSC)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_req(evt_req),
    .slot_in(slot_in), .prog_done(prog_done), .prog_start(prog_start), .prog_task(prog_task),
    .prog_evt(prog_evt), .in_read(in_read), .out_write(out_write), .io_grp_sel(io_grp_sel),
    .out_fallback(out_fallback), .alarm_output(alarm_output), .app_fault(app_fault));
  scw_app_model app (.sys_clk(sys_clk), .rst_b(rst_b), .prog_start(prog_start), .in_read(in_read),
    .out_write(out_write), .prog_task(prog_task), .prg_len(prg_len), .prog_done(prog_done), .order_err(order_err),
    .n_start(n_start));
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi, input string what);
    chk({15'h0000, got >= 16'(lo) && got <= 16'(hi)}, 16'h0001, what);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdv(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic wait_for(input int b, input int lim, input string what);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (sig[b] === 1'b1)
        break;
    end
    if (i == lim)
    begin
      fail_count++;
      $display("mismatch at %0t: timeout on %s", $time, what);
      end_sim();
    end
  endtask
  logic [3:0]  ra[7] = '{A_MPER, A_PPER, A_LIMIT, A_P_LONG, A_P_SHORT, 4'hd, 4'hf};
  logic [15:0] rv[7] = '{16'h000a, 16'h0005, 16'h00fa, 16'h0000, 16'hffff, 16'h0000, 16'h0000};
  // Main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    chk({15'h0000, alarm_output}, 16'h0001, "alarm in reset");
    rst_b <= 1'b1;
    wr(A_CTRL, 16'h000b);
    wait_for(2, 100, "first scan");
    rdv(A_CTRL);
    chk(rd, 16'h0009, "fast enable cleared");
    foreach (ra[i])
    begin
      rdv(ra[i]);
      chk(rd, rv[i], "reset value");
    end
    rdv(A_M_SHORT);
    chk_rng(rd, 2, 5, "first short");
    wr(A_LIMIT, 16'h0258);
    rdv(A_LIMIT);
    chk(rd, 16'h01f4, "limit clamp");
    wr(A_MPER, 16'h0000);
    rdv(A_MPER);
    chk(rd, 16'h000a, "zero period");
    wr(A_LIMIT, 16'h00fa);
    $display("test reset done");
    prg_len <= 16'(3 * MSC);
    repeat (3) wait_for(2, 20 * MSC, "cyclic scan");
    rdv(A_M_LAST);
    chk_rng(rd, 3, 5, "last scan");
    prg_len <= 16'(MSC);
    repeat (3) wait_for(2, 20 * MSC, "cyclic scan");
    rdv(A_M_SHORT);
    chk_rng(rd, 1, 2, "shortest");
    rdv(A_M_LONG);
    chk_rng(rd, 3, 5, "longest");
    chk(16'(order_err), 16'h0000, "scan order");
    $display("test cyclic done");
    prg_len <= 16'h0003;
    wr(A_MPER, 16'h0004);
    wr(A_CTRL, 16'h0019);
    repeat (2) wait_for(0, 20 * MSC, "periodic scan");
    n0 = cyc;
    wait_for(0, 20 * MSC, "periodic scan");
    chk_rng(16'(cyc - n0), 3 * MSC, 5 * MSC, "scan spacing");
    rdv(A_STATUS);
    chk(rd & 16'h0001, 16'h0000, "no overrun");
    prg_len <= 16'(6 * MSC);
    repeat (2) wait_for(2, 20 * MSC, "long scan");
    wait_for(0, 4, "restart after write");
    rdv(A_STATUS);
    chk(rd & 16'h0001, 16'h0001, "period overrun");
    $display("test periodic done");
    prg_len <= 16'h0003;
    wr(A_CTRL, 16'h0001);
    repeat (10 * MSC) @(posedge sys_clk);
    n0 = n_start;
    wait_for(0, 20 * MSC, "stop read");
    chk({15'h0000, out_fallback}, 16'h0001, "fallback");
    chk(16'(n_start - n0), 16'h0000, "no program in stop");
    wr(A_CTRL, 16'h0021);
    repeat (4) @(posedge sys_clk);
    chk({15'h0000, out_fallback}, 16'h0000, "hold");
    $display("test stop done");
    wr(A_GROUP, 16'h0005);
    wr(A_PPER, 16'h0002);
    wr(A_CTRL, 16'h004b);
    wait_for(4, 20 * MSC, "fast start");
    chk({12'h000, io_grp_sel}, 16'h0005, "fast groups");
    wait_for(6, 20 * MSC, "main start");
    chk({12'h000, io_grp_sel}, 16'h000a, "main groups");
    wait_for(4, 20 * MSC, "fast again");
    rdv(A_P_LAST);
    chk_rng(rd, 0, 1, "fast last");
    $display("test fast done");
    wr(A_CTRL, 16'h000d);
    evt_req <= 8'h20;
    @(posedge sys_clk);
    evt_req <= 8'h00;
    wait_for(5, 20 * MSC, "event start");
    chk({10'h000, prog_evt}, 16'h0005, "event number");
    chk_rng(16'(cyc - t_in), 0, 4, "event inputs");
    wr(A_EDGE, 16'h0002);
    slot_in <= 4'h2;
    repeat (4 * MSC) @(posedge sys_clk);
    slot_in <= 4'h0;
    wait_for(5, 20 * MSC, "edge event");
    chk({10'h000, prog_evt}, 16'h0001, "edge event number");
    $display("test event done");
    wr(A_CTRL, 16'h0009);
    wr(A_LIMIT, 16'h0003);
    prg_len <= 16'(10 * MSC);
    wait_for(3, 20 * MSC, "watchdog");
    // Alarm is registered from the fault, one cycle behind it
    @(posedge sys_clk);
    #1 chk({15'h0000, alarm_output}, 16'h0000, "alarm low");
    rdv(A_STATUS);
    chk(rd & 16'h0006, 16'h0006, "watchdog flags");
    n0 = n_start;
    repeat (4 * MSC) @(posedge sys_clk);
    chk(16'(n_start - n0), 16'h0000, "halted");
    $display("test watchdog done");
    end_sim();
  end
endmodule
